//--- rtl/bcd_pkg.sv
// Purpose: shared constants and types for the bit-op and carry-add decoder
// Assumes: one byte-wide instruction stream, 4-bit data nibbles, 12-bit nibble addresses
// Notes:   opcodes, field values and memory windows are named here only once
package bcd_pkg;

  // ***************************************************************
  // opcodes (first byte)
  // ***************************************************************
  localparam logic [7:0] OPC_ADC_AHL  = 8'h3E;
  localparam logic [7:0] OPC_PAIR_PFX = 8'hDC;
  localparam logic [3:0] OPC_ADS_AIM  = 4'hA;
  localparam logic [7:0] OPC_BIT_CLR  = 8'hFE;
  localparam logic [7:0] OPC_C_AND    = 8'hF5;
  localparam logic [7:0] OPC_C_OR     = 8'hF6;
  localparam logic [7:0] OPC_C_XOR    = 8'hF7;
  localparam logic [7:0] OPC_C_STORE  = 8'hFC;
  localparam logic [7:0] OPC_C_LOAD   = 8'hF4;
  localparam logic [1:0] DIRCLR_HI    = 2'h3;
  localparam logic [3:0] DIRCLR_LO    = 4'h0;

  // ***************************************************************
  // second-byte fields, window bases and instruction lengths
  // ***************************************************************
  localparam logic [4:0] ADC_TO_EA    = 5'h15;
  localparam logic [4:0] ADC_TO_PAIR  = 5'h14;
  localparam logic [1:0] FORM_PTR     = 2'h0;
  localparam logic [1:0] FORM_IDX     = 2'h1;
  localparam logic [1:0] FORM_WIN0    = 2'h2;
  localparam logic [1:0] FORM_WIN1    = 2'h3;
  localparam logic [7:0] WIN0_BASE    = 8'hFB;
  localparam logic [7:0] WIN1_BASE    = 8'hFF;
  localparam logic [3:0] IDX_BANK     = 4'hF;
  localparam logic [1:0] PAIR_EA      = 2'h0;
  localparam logic [1:0] PAIR_PTR     = 2'h1;
  localparam logic [1:0] LEN_ONE      = 2'h1;
  localparam logic [1:0] LEN_TWO      = 2'h2;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [4:0] {
    ST_FETCH  = 5'h01,
    ST_FETCH2 = 5'h02,
    ST_RD     = 5'h04,
    ST_EXEC   = 5'h08,
    ST_IDLE   = 5'h10
  } bcd_state_type;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADC_AHL, OP_PAIR, OP_DIRCLR, OP_CLR, OP_AND, OP_OR, OP_XOR, OP_STORE, OP_LOAD
  } bcd_op_type;

  typedef struct packed {
    logic        ok;
    logic [11:0] addr;
    logic [1:0]  bsel;
  } bcd_bitaddr_type;

endpackage

//--- rtl/bcd_core.sv
// Purpose: decode and execute bit ops, carry/bit moves and add-with-carry
// Assumes: memory read data is valid the cycle after mem_rd; same clock as the core
// Notes:   one instruction at a time; ins_ready stalls the fetch stream
//
// Contract
// - add-with-carry writes sum, source untouched
// - carry set on overflow, cleared otherwise
// - overflowing ADC A,@HL skips following immediate add
// - only ADC A,@HL arms that skip
// - ADC A,@HL single byte, one cycle; core takes three clocks (fetch, read, execute)
// - pair form to extended_accumulator, two bytes
// - pair form to dest_pair, bit3 zero
// - indexed form: operand bits plus pointer low
// - carry AND addressed bit
// - carry OR addressed bit, opcode F6
// - carry XOR addressed bit, opcode F7
// - second byte 10/11 picks I/O window
// - store carry into addressed bit
// - load addressed bit into carry, opcode F4
// - direct bit clear with address byte
`timescale 1ns/1ps
module bcd_core
  import bcd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // instruction stream
  input  wire logic        ins_valid,
  input  wire logic [7:0]  ins_byte,
  output logic             ins_ready_ff,
  // data memory
  input  wire logic [3:0]  data_bank,
  input  wire logic [3:0]  mem_rdata,
  output logic [11:0]      mem_addr_ff,
  output logic             mem_rd_ff,
  output logic             mem_wr_ff,
  output logic [3:0]       mem_wdata_ff,
  // core state
  output logic             carry_ff,
  output logic [7:0]       ea_ff,
  output logic             instr_done_ff,
  output logic [1:0]       instr_len_ff,
  output logic             skipped_ff,
  output logic             illegal_ff
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic bcd_bitaddr_type bit_addr(input logic [7:0] b2, input logic [7:0] hl,
                                               input logic [3:0] bank);
    bcd_bitaddr_type r;
    r = '{ok: 1'b1, addr: {bank, hl[7:4], b2[3:0]}, bsel: b2[5:4]};
    case (b2[7:6])
      FORM_IDX:  r = '{ok: (b2[5:4] == 2'h0), addr: {IDX_BANK, b2[5:0], hl[3:2]}, bsel: hl[1:0]};
      FORM_WIN0: r.addr = {WIN0_BASE, b2[3:0]};
      FORM_WIN1: r.addr = {WIN1_BASE, b2[3:0]};
      default:   r.addr = {bank, hl[7:4], b2[3:0]};
    endcase
    return r;
  endfunction

  function automatic logic [3:0] put_bit(input logic [3:0] d, input logic [1:0] i, input logic v);
    logic [3:0] r;
    r    = d;
    r[i] = v;
    return r;
  endfunction

  // ***************************************************************
  // state
  // ***************************************************************
  bcd_state_type   state_ff, nxt_state;
  bcd_op_type      op_ff, nxt_op;
  logic [7:0]      byte1_ff, nxt_byte1;
  logic [1:0]      bit_ff, nxt_bit;
  logic [7:0]      pair_ff [4];
  logic [7:0]      nxt_pair [4];
  logic            skip_pend_ff, nxt_skip_pend;
  logic            nxt_carry, nxt_ready, nxt_rd, nxt_wr, nxt_done, nxt_skipped, nxt_illegal;
  logic [11:0]     nxt_addr;
  logic [3:0]      nxt_wdata;
  logic [1:0]      nxt_len;
  logic            take;
  logic [8:0]      sum8;
  logic [4:0]      sum4;
  logic            mbit;
  bcd_bitaddr_type ba;

  assign take = ins_valid & ins_ready_ff;
  assign mbit = mem_rdata[bit_ff];

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_op        = op_ff;
    nxt_byte1     = byte1_ff;
    nxt_bit       = bit_ff;
    nxt_pair      = pair_ff;
    nxt_skip_pend = skip_pend_ff;
    nxt_carry     = carry_ff;
    nxt_ready     = ins_ready_ff;
    nxt_rd        = 1'b0;
    nxt_wr        = 1'b0;
    nxt_addr      = mem_addr_ff;
    nxt_wdata     = mem_wdata_ff;
    nxt_done      = 1'b0;
    nxt_len       = instr_len_ff;
    nxt_skipped   = 1'b0;
    nxt_illegal   = 1'b0;
    sum8          = 9'h000;
    sum4          = 5'h00;
    ba            = bit_addr(ins_byte, pair_ff[PAIR_PTR], data_bank);
    case (state_ff)
      ST_IDLE:
      begin
        nxt_state = ST_FETCH;
        nxt_ready = 1'b1;
      end
      ST_FETCH:
        if (take)
        begin
          nxt_byte1     = ins_byte;
          nxt_skip_pend = 1'b0;
          nxt_len       = LEN_ONE;
          if (ins_byte == OPC_ADC_AHL)
          begin
            // read (H,L) now; single byte, so finishes as a one-byte instruction
            nxt_op    = OP_ADC_AHL;
            nxt_addr  = {data_bank, pair_ff[PAIR_PTR]};
            nxt_rd    = 1'b1;
            nxt_ready = 1'b0;
            nxt_state = ST_RD;
          end
          else if (ins_byte[7:4] == OPC_ADS_AIM)
          begin
            nxt_done = 1'b1;
            if (skip_pend_ff)
              nxt_skipped = 1'b1;
            else
              nxt_pair[PAIR_EA][3:0] = ins_byte[3:0] + pair_ff[PAIR_EA][3:0];
          end
          else if (ins_byte == OPC_PAIR_PFX || ins_byte == OPC_BIT_CLR || ins_byte == OPC_C_AND ||
                   ins_byte == OPC_C_OR || ins_byte == OPC_C_XOR || ins_byte == OPC_C_STORE ||
                   ins_byte == OPC_C_LOAD ||
                   (ins_byte[7:6] == DIRCLR_HI && ins_byte[3:0] == DIRCLR_LO))
            nxt_state = ST_FETCH2;
          else
          begin
            nxt_done    = 1'b1;
            nxt_illegal = 1'b1;
          end
        end
      ST_FETCH2:
        if (take)
        begin
          nxt_len   = LEN_TWO;
          nxt_bit   = ba.bsel;
          nxt_addr  = ba.addr;
          nxt_rd    = 1'b1;
          nxt_ready = 1'b0;
          nxt_state = ST_RD;
          case (byte1_ff)
            OPC_PAIR_PFX: nxt_op = OP_PAIR;
            OPC_BIT_CLR:  nxt_op = OP_CLR;
            OPC_C_AND:    nxt_op = OP_AND;
            OPC_C_OR:     nxt_op = OP_OR;
            OPC_C_XOR:    nxt_op = OP_XOR;
            OPC_C_STORE:  nxt_op = OP_STORE;
            OPC_C_LOAD:   nxt_op = OP_LOAD;
            default:
            begin
              nxt_op   = OP_DIRCLR;
              nxt_bit  = byte1_ff[5:4];
              nxt_addr = {data_bank, ins_byte};
            end
          endcase
          if (byte1_ff == OPC_PAIR_PFX)
          begin
            // register pair add needs no memory; it completes here
            nxt_rd    = 1'b0;
            nxt_ready = 1'b1;
            nxt_state = ST_FETCH;
            nxt_done  = 1'b1;
            if (ins_byte[0] == 1'b0 && ins_byte[7:3] == ADC_TO_EA)
            begin
              sum8                = {1'b0, pair_ff[PAIR_EA]} + {1'b0, pair_ff[ins_byte[2:1]]} + {8'h00, carry_ff};
              nxt_pair[PAIR_EA]   = sum8[7:0];
              nxt_carry           = sum8[8];
            end
            else if (ins_byte[0] == 1'b0 && ins_byte[7:3] == ADC_TO_PAIR)
            begin
              sum8                      = {1'b0, pair_ff[ins_byte[2:1]]} + {1'b0, pair_ff[PAIR_EA]} +
                                          {8'h00, carry_ff};
              nxt_pair[ins_byte[2:1]] = sum8[7:0];
              nxt_carry                 = sum8[8];
            end
            else
              nxt_illegal = 1'b1;
          end
          else if (byte1_ff != OPC_PAIR_PFX && byte1_ff[3:0] != DIRCLR_LO && !ba.ok)
          begin
            nxt_rd      = 1'b0;
            nxt_ready   = 1'b1;
            nxt_state   = ST_FETCH;
            nxt_done    = 1'b1;
            nxt_illegal = 1'b1;
          end
        end
      ST_RD:
        nxt_state = ST_EXEC;
      ST_EXEC:
      begin
        nxt_state = ST_FETCH;
        nxt_ready = 1'b1;
        nxt_done  = 1'b1;
        case (op_ff)
          OP_ADC_AHL:
          begin
            sum4                   = {1'b0, pair_ff[PAIR_EA][3:0]} + {1'b0, mem_rdata} + {4'h0, carry_ff};
            nxt_pair[PAIR_EA][3:0] = sum4[3:0];
            nxt_carry              = sum4[4];
            nxt_skip_pend          = sum4[4];
          end
          OP_CLR, OP_DIRCLR:
          begin
            nxt_wr    = 1'b1;
            nxt_wdata = put_bit(mem_rdata, bit_ff, 1'b0);
          end
          OP_STORE:
          begin
            nxt_wr    = 1'b1;
            nxt_wdata = put_bit(mem_rdata, bit_ff, carry_ff);
          end
          OP_AND:  nxt_carry = carry_ff & mbit;
          OP_OR:   nxt_carry = carry_ff | mbit;
          OP_XOR:  nxt_carry = carry_ff ^ mbit;
          OP_LOAD: nxt_carry = mbit;
          default: nxt_illegal = 1'b1;
        endcase
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_ff      <= ST_IDLE;
      op_ff         <= OP_NONE;
      byte1_ff      <= 8'h00;
      bit_ff        <= 2'h0;
      pair_ff       <= '{default: 8'h00};
      skip_pend_ff  <= 1'b0;
      carry_ff      <= 1'b0;
      ins_ready_ff  <= 1'b0;
      mem_addr_ff   <= 12'h000;
      mem_rd_ff     <= 1'b0;
      mem_wr_ff     <= 1'b0;
      mem_wdata_ff  <= 4'h0;
      instr_done_ff <= 1'b0;
      instr_len_ff  <= 2'h0;
      skipped_ff    <= 1'b0;
      illegal_ff    <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      op_ff         <= nxt_op;
      byte1_ff      <= nxt_byte1;
      bit_ff        <= nxt_bit;
      pair_ff       <= nxt_pair;
      skip_pend_ff  <= nxt_skip_pend;
      carry_ff      <= nxt_carry;
      ins_ready_ff  <= nxt_ready;
      mem_addr_ff   <= nxt_addr;
      mem_rd_ff     <= nxt_rd;
      mem_wr_ff     <= nxt_wr;
      mem_wdata_ff  <= nxt_wdata;
      instr_done_ff <= nxt_done;
      instr_len_ff  <= nxt_len;
      skipped_ff    <= nxt_skipped;
      illegal_ff    <= nxt_illegal;
    end
  end

  always_comb ea_ff = pair_ff[PAIR_EA];

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_ADC_SUM: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_EXEC && op_ff == OP_ADC_AHL) |=>
    {carry_ff, ea_ff[3:0]} == $past(ea_ff[3:0]) + $past(mem_rdata) + $past(carry_ff))
    else $error("adc sum wrong");
  AST_ADC_CARRY: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_FETCH2 && take && byte1_ff == OPC_PAIR_PFX && ins_byte[7:3] == ADC_TO_EA && !ins_byte[0])
    |=> carry_ff == ($past({1'b0, ea_ff}) + $past({1'b0, pair_ff[ins_byte[2:1]]}) + $past({8'h00, carry_ff})) > 9'h0FF)
    else $error("pair carry wrong");
  AST_SKIP_ADS: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_FETCH && take && ins_byte[7:4] == OPC_ADS_AIM && skip_pend_ff) |=> skipped_ff && $stable(ea_ff))
    else $error("immediate add not skipped");
  AST_NO_SKIP: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_FETCH && take && op_ff != OP_ADC_AHL) |=> !skipped_ff ##1 !skip_pend_ff)
    else $error("skip armed by wrong instruction");
  AST_ADC_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_FETCH && take && ins_byte == OPC_ADC_AHL) |=> mem_rd_ff ##2 instr_done_ff && instr_len_ff == LEN_ONE)
    else $error("adc length wrong");
  AST_PAIR_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_FETCH2 && take && byte1_ff == OPC_PAIR_PFX) |=> instr_done_ff && instr_len_ff == LEN_TWO)
    else $error("pair add length wrong");
  AST_CLR_BIT: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_EXEC && (op_ff == OP_CLR || op_ff == OP_DIRCLR)) |=>
    mem_wr_ff && !mem_wdata_ff[$past(bit_ff)])
    else $error("bit not cleared");
  AST_OR_BIT: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_EXEC && op_ff == OP_OR) |=> carry_ff == ($past(carry_ff) | $past(mbit)))
    else $error("carry or wrong");
  AST_IO_WIN: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_FETCH2 && take && byte1_ff == OPC_C_LOAD && ins_byte[7:6] == FORM_WIN0) |=>
    mem_addr_ff[11:4] == WIN0_BASE && mem_rd_ff)
    else $error("io window wrong");
  AST_STORE: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == ST_EXEC && op_ff == OP_STORE) |=> mem_wr_ff && mem_wdata_ff[$past(bit_ff)] == $past(carry_ff))
    else $error("carry store wrong");

endmodule

//--- dv/tb.sv
// Purpose: self-checking bench for the bit-op and carry-add decoder
// Assumes: nibble memory modelled here answers with no wait; pairs start at zero
// Notes:   ordinary bit ops come from a row table; add-with-carry and odd cases by hand
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb;

  // ***************************************************************
  // signals
  // ***************************************************************
  typedef struct packed {
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic        cin;
    logic [3:0]  mval;
    logic [11:0] addr;
    logic        c;
    logic [3:0]  m;
  } bcd_row_type;

  // first byte, second byte, carry in, nibble before, address, carry out, nibble after
  localparam bcd_row_type ROWS [0:16] = '{
    '{8'hFE, 8'h85, 1'h0, 4'hF, 12'hFB5, 1'h0, 4'hE},
    '{8'hFE, 8'hD3, 1'h0, 4'hF, 12'hFF3, 1'h0, 4'hD},
    '{8'hFE, 8'h2A, 1'h0, 4'hF, 12'h30A, 1'h0, 4'hB},
    '{8'hFE, 8'h45, 1'h0, 4'hF, 12'hF14, 1'h0, 4'hE},
    '{8'hF0, 8'h7C, 1'h0, 4'hF, 12'h37C, 1'h0, 4'h7},
    '{8'hF5, 8'h81, 1'h1, 4'h1, 12'hFB1, 1'h1, 4'h1},
    '{8'hF5, 8'h81, 1'h1, 4'hE, 12'hFB1, 1'h0, 4'hE},
    '{8'hF5, 8'h37, 1'h1, 4'h8, 12'h307, 1'h1, 4'h8},
    '{8'hF6, 8'hE2, 1'h0, 4'h4, 12'hFF2, 1'h1, 4'h4},
    '{8'hF6, 8'hE2, 1'h0, 4'hB, 12'hFF2, 1'h0, 4'hB},
    '{8'hF6, 8'h4C, 1'h0, 4'h1, 12'hF30, 1'h1, 4'h1},
    '{8'hF7, 8'h93, 1'h1, 4'h2, 12'hFB3, 1'h0, 4'h2},
    '{8'hF7, 8'h93, 1'h1, 4'h0, 12'hFB3, 1'h1, 4'h0},
    '{8'hFC, 8'h16, 1'h1, 4'h0, 12'h306, 1'h1, 4'h2},
    '{8'hFC, 8'hF1, 1'h0, 4'hF, 12'hFF1, 1'h0, 4'h7},
    '{8'hF4, 8'hA4, 1'h0, 4'h4, 12'hFB4, 1'h1, 4'h4},
    '{8'hF4, 8'h48, 1'h1, 4'hE, 12'hF20, 1'h0, 4'hE}
  };

  logic        clk;
  logic        rst_b;
  logic        ins_valid;
  logic [7:0]  ins_byte;
  logic        ins_ready_ff;
  logic [3:0]  data_bank;
  logic [3:0]  mem_rdata;
  logic [11:0] mem_addr_ff;
  logic        mem_rd_ff;
  logic        mem_wr_ff;
  logic [3:0]  mem_wdata_ff;
  logic        carry_ff;
  logic [7:0]  ea_ff;
  logic        instr_done_ff;
  logic [1:0]  instr_len_ff;
  logic        skipped_ff;
  logic        illegal_ff;
  logic [3:0]  mem [0:4095];
  logic        rd_q = 1'h0;
  logic [11:0] last_addr;
  logic [7:0]  e;
  logic        c;
  int          skips = 0;
  int          errors = 0;
  int          checked = 0;

  bcd_core bcd_core_i (
    .clk           (clk),
    .rst_b         (rst_b),
    .ins_valid     (ins_valid),
    .ins_byte      (ins_byte),
    .ins_ready_ff  (ins_ready_ff),
    .data_bank     (data_bank),
    .mem_rdata     (mem_rdata),
    .mem_addr_ff   (mem_addr_ff),
    .mem_rd_ff     (mem_rd_ff),
    .mem_wr_ff     (mem_wr_ff),
    .mem_wdata_ff  (mem_wdata_ff),
    .carry_ff      (carry_ff),
    .ea_ff         (ea_ff),
    .instr_done_ff (instr_done_ff),
    .instr_len_ff  (instr_len_ff),
    .skipped_ff    (skipped_ff),
    .illegal_ff    (illegal_ff)
  );

  // ***************************************************************
  // clock and memory model
  // ***************************************************************
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // outside the read window the nibble is inverted so a late sample cannot pass
  assign mem_rdata = (mem_rd_ff | rd_q) ? mem[mem_addr_ff] : ~mem[mem_addr_ff];

  always @(posedge clk) rd_q <= mem_rd_ff;

  always @(negedge clk)
  begin
    if (mem_wr_ff === 1'h1) mem[mem_addr_ff] <= mem_wdata_ff;
    if (mem_rd_ff === 1'h1) last_addr <= mem_addr_ff;
    if (instr_done_ff === 1'h1 && skipped_ff === 1'h1) skips++;
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // holds the byte until an edge that sees ready high; valid stays up for back-to-back use
  task automatic send(input logic [7:0] b);
    int   n;
    logic r;
    n = 0;
    r = 1'h0;
    ins_valid <= 1'h1;
    ins_byte  <= b;
    while (r !== 1'h1 && n < 20)
    begin
      @(negedge clk);
      r = ins_ready_ff;
      @(posedge clk);
      n++;
    end
    if (r !== 1'h1)
    begin
      errors++;
      results();
    end
  endtask

  task automatic wait_done(input logic [1:0] len, input logic sk, input logic il, input logic mop);
    int n;
    n = 0;
    ins_valid <= 1'h0;
    @(negedge clk);
    if (mop) `CHK("ready", 1'h0, ins_ready_ff)
    while (instr_done_ff !== 1'h1 && n < 20)
    begin
      n++;
      @(negedge clk);
    end
    if (n >= 20)
    begin
      errors++;
      results();
    end
    `CHK("len", len, instr_len_ff)
    `CHK("skipped", sk, skipped_ff)
    `CHK("illegal", il, illegal_ff)
    @(posedge clk);
  endtask

  // carry has no input port, so it is loaded from a spare window bit
  task automatic set_carry(input logic cv);
    mem[12'hFB0] = {3'h0, cv};
    send(8'hF4);
    send(8'h80);
    wait_done(2'h2, 1'h0, 1'h0, 1'h1);
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    rst_b     <= 1'h0;
    ins_valid <= 1'h0;
    ins_byte  <= 8'h00;
    data_bank <= 4'h3;
    foreach (mem[i]) mem[i] = 4'h0;
    repeat (16) @(posedge clk);
    `CHK("ready", 1'h0, ins_ready_ff)
    `CHK("ea", 8'h00, ea_ff)
    rst_b <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    // the idle state hands over to fetch at the first edge after release
    `CHK("ready", 1'h1, ins_ready_ff)
    @(negedge clk);
    `CHK("ready", 1'h1, ins_ready_ff)
    @(posedge clk);
    for (int r = 0; r < 17; r++)
    begin
      set_carry(ROWS[r].cin);
      mem[ROWS[r].addr] = ROWS[r].mval;
      send(ROWS[r].b1);
      send(ROWS[r].b2);
      wait_done(2'h2, 1'h0, 1'h0, 1'h1);
      `CHK("addr", ROWS[r].addr, last_addr)
      `CHK("carry", ROWS[r].c, carry_ff)
      `CHK("nibble", ROWS[r].m, mem[ROWS[r].addr])
    end
    // overflowing accumulator add drops the next immediate add
    set_carry(1'h0);
    mem[12'h300] = 4'h9;
    send(8'hA8);
    wait_done(2'h1, 1'h0, 1'h0, 1'h0);
    send(8'h3E);
    wait_done(2'h1, 1'h0, 1'h0, 1'h1);
    `CHK("ea", 8'h01, ea_ff)
    `CHK("carry", 1'h1, carry_ff)
    `CHK("src", 4'h9, mem[12'h300])
    `CHK("addr", 12'h300, last_addr)
    send(8'hAA);
    wait_done(2'h1, 1'h1, 1'h0, 1'h0);
    `CHK("ea", 8'h01, ea_ff)
    // back to back: no overflow, then an immediate add that overflows, then one more
    mem[12'h300] = 4'h4;
    send(8'h3E);
    send(8'hAC);
    send(8'hA1);
    wait_done(2'h1, 1'h0, 1'h0, 1'h0);
    repeat (2) @(posedge clk);
    `CHK("ea", 8'h03, ea_ff)
    `CHK("carry", 1'h0, carry_ff)
    `CHK("skips", 1, skips)
    // register pair forms
    send(8'hDC);
    send(8'hA2);
    wait_done(2'h2, 1'h0, 1'h0, 1'h0);
    `CHK("ea", 8'h03, ea_ff)
    send(8'hDC);
    send(8'hAA);
    wait_done(2'h2, 1'h0, 1'h0, 1'h0);
    `CHK("ea", 8'h06, ea_ff)
    e = 8'h06;
    c = 1'h0;
    for (int k = 0; k < 7; k++)
    begin
      send(8'hDC);
      send(8'hA8);
      wait_done(2'h2, 1'h0, 1'h0, 1'h0);
      {c, e} = {1'h0, e} + {1'h0, e} + {8'h00, c};
      `CHK("ea", e, ea_ff)
      `CHK("carry", c, carry_ff)
    end
    send(8'hDC);
    send(8'hA2);
    wait_done(2'h2, 1'h0, 1'h0, 1'h0);
    `CHK("carry", 1'h0, carry_ff)
    // pointer low is now 5: nibble F15, bit 1
    set_carry(1'h0);
    mem[12'hF15] = 4'h2;
    send(8'hF4);
    send(8'h45);
    wait_done(2'h2, 1'h0, 1'h0, 1'h1);
    `CHK("addr", 12'hF15, last_addr)
    `CHK("carry", 1'h1, carry_ff)
    send(8'hFE);
    send(8'h45);
    wait_done(2'h2, 1'h0, 1'h0, 1'h1);
    `CHK("nibble", 4'h0, mem[12'hF15])
    send(8'hF5);
    send(8'h70);
    wait_done(2'h2, 1'h0, 1'h1, 1'h0);
    `CHK("carry", 1'h1, carry_ff)
    results();
  end

endmodule
